// file: uadc_defines.svh
// Behaviour
// [RULE1] device acts only as peripheral; never starts bus transactions itself.
// [RULE2] full speed signalling, line drivers driven directly, no external transceiver.
// [RULE3] endpoint set follows the wireless standard's usb transport; engine outside.
// [RULE4] pull-up on d+ enabled only when ready to enumerate.
// [RULE5] pull-up source selectable: internal by default, else external via io pin.
// [RULE6] self-powered default: pull-up off whenever bus power sense reads off.
// [RULE7] bus power sense taken from io pin index 2 unless configured elsewhere.
// [RULE8] detach input and wake output mappable to any io pin.
// [RULE9] detach high floats both data lines and disables pull-up.
// [RULE10] detach low reconnects pull-up and lines, then awaits enumeration.
// [RULE11] wake output active high, asserted only while detached.
// [RULE12] no in-band remote wakeup while detached; wake goes out-of-band only.
// [RULE13] with high-speed host, stay at full speed; no high-speed chirp.
// [RULE14] bus-powered mode declares power in enumeration; off by default.
// [RULE15] detach and bus power sense pass two-flop synchronisers first.
// [RULE16] after reset pull-up off, lines floated, wake low until config applied.
`ifndef UADC_DEFINES_SVH
`define UADC_DEFINES_SVH
`define UADC_PIN_COUNT       10
`define UADC_PIN_IDX_W       4
`define UADC_SENSE_PIN_RST   4'h2
`define UADC_DETACH_PIN_RST  4'h3
`define UADC_WAKE_PIN_RST    4'h4
`define UADC_PULLUP_PIN_RST  4'h5
`endif

// file: uadc_pkg.sv
package uadc_pkg;
	typedef enum logic [1:0] {
		UADC_PULL_INTERNAL,
		UADC_PULL_EXTERNAL
	} uadc_pull_src_t;
	typedef enum logic [1:0] {
		UADC_ST_INIT,
		UADC_ST_OFF,
		UADC_ST_ATTACHED,
		UADC_ST_DETACHED
	} uadc_state_t;
endpackage : uadc_pkg

// file: uadc_sync2.sv
`timescale 1ns/1ns
module uadc_sync2 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;
	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else if (ce) begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : uadc_sync2

// file: uadc_attach_ctrl.sv
`timescale 1ns/1ns
`include "uadc_defines.svh"
module uadc_attach_ctrl (
	input  wire logic                          CLOCK,
	input  wire logic                          SYS_RST,
	input  wire logic                          CLK_EN,
	input  wire logic                          CFG_VALID,
	input  wire logic                          CFG_PULL_EXTERNAL,
	input  wire logic                          CFG_BUS_POWERED,
	input  wire logic [`UADC_PIN_IDX_W-1:0]    CFG_SENSE_PIN,
	input  wire logic [`UADC_PIN_IDX_W-1:0]    CFG_DETACH_PIN,
	input  wire logic [`UADC_PIN_IDX_W-1:0]    CFG_WAKE_PIN,
	input  wire logic [`UADC_PIN_IDX_W-1:0]    CFG_PULLUP_PIN,
	input  wire logic                          CORE_READY,
	input  wire logic                          CORE_WAKE_REQ,
	input  wire logic [`UADC_PIN_COUNT-1:0]    PROGRAMMABLE_IO_PIN_IN,
	output logic      [`UADC_PIN_COUNT-1:0]    PROGRAMMABLE_IO_PIN_OUT,
	output logic      [`UADC_PIN_COUNT-1:0]    PROGRAMMABLE_IO_PIN_OE,
	output logic                               INT_PULLUP_EN,
	output logic                               LINE_DRIVE_ALLOW,
	output logic                               INBAND_WAKE_ALLOW,
	output logic                               HS_CHIRP_INHIBIT,
	output logic                               PERIPHERAL_ONLY,
	output logic                               DECLARE_BUS_POWER,
	output logic                               BUS_POWER_RAIL_OK,
	output logic                               DETACHED
);
	// ==========================================================
	// configuration latch
	logic                       cfg_done_q;
	logic                       pull_ext_q;
	logic                       bus_pwr_q;
	logic [`UADC_PIN_IDX_W-1:0] sense_pin_q;
	logic [`UADC_PIN_IDX_W-1:0] detach_pin_q;
	logic [`UADC_PIN_IDX_W-1:0] wake_pin_q;
	logic [`UADC_PIN_IDX_W-1:0] pull_pin_q;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cfg_done_q   <= 1'b0;
			pull_ext_q   <= 1'b0;
			bus_pwr_q    <= 1'b0;
			sense_pin_q  <= `UADC_SENSE_PIN_RST; // RULE7
			detach_pin_q <= `UADC_DETACH_PIN_RST;
			wake_pin_q   <= `UADC_WAKE_PIN_RST;
			pull_pin_q   <= `UADC_PULLUP_PIN_RST;
		end else if (CLK_EN && CFG_VALID) begin
			cfg_done_q   <= 1'b1;
			pull_ext_q   <= CFG_PULL_EXTERNAL; // RULE5
			bus_pwr_q    <= CFG_BUS_POWERED; // RULE14
			sense_pin_q  <= CFG_SENSE_PIN; // RULE7
			detach_pin_q <= CFG_DETACH_PIN; // RULE8
			wake_pin_q   <= CFG_WAKE_PIN; // RULE8
			pull_pin_q   <= CFG_PULLUP_PIN; // RULE5
		end
	end

	// ==========================================================
	// pin selection and synchronisers
	function automatic logic pick_pin(input logic [`UADC_PIN_COUNT-1:0] pins,
		input logic [`UADC_PIN_IDX_W-1:0] idx);
		pick_pin = (idx < `UADC_PIN_IDX_W'(`UADC_PIN_COUNT)) ? pins[idx] : 1'b0;
	endfunction : pick_pin

	logic sense_s;
	logic detach_s;

	uadc_sync2 u_sense_sync ( // RULE15
		.clk  (CLOCK),
		.rst  (SYS_RST),
		.ce   (CLK_EN),
		.din  (pick_pin(PROGRAMMABLE_IO_PIN_IN, sense_pin_q)),
		.dout (sense_s)
	);

	uadc_sync2 u_detach_sync ( // RULE15
		.clk  (CLOCK),
		.rst  (SYS_RST),
		.ce   (CLK_EN),
		.din  (pick_pin(PROGRAMMABLE_IO_PIN_IN, detach_pin_q)),
		.dout (detach_s)
	);

	// ==========================================================
	// attach state machine
	uadc_pkg::uadc_state_t state_q;
	uadc_pkg::uadc_state_t state_d;
	logic                  power_ok;

	// bus-powered parts are alive only with rail up, so sense gates both modes
	assign power_ok = sense_s; // RULE6

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			uadc_pkg::UADC_ST_INIT: begin
				if (cfg_done_q) begin
					state_d = uadc_pkg::UADC_ST_OFF; // RULE16
				end
			end
			uadc_pkg::UADC_ST_OFF: begin
				if (detach_s) begin
					state_d = uadc_pkg::UADC_ST_DETACHED; // RULE9
				end else if (power_ok && CORE_READY) begin
					state_d = uadc_pkg::UADC_ST_ATTACHED; // RULE4
				end
			end
			uadc_pkg::UADC_ST_ATTACHED: begin
				if (detach_s) begin
					state_d = uadc_pkg::UADC_ST_DETACHED; // RULE9
				end else if (!power_ok || !CORE_READY) begin
					state_d = uadc_pkg::UADC_ST_OFF; // RULE6
				end
			end
			uadc_pkg::UADC_ST_DETACHED: begin
				if (!detach_s) begin
					state_d = uadc_pkg::UADC_ST_OFF; // RULE10
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q <= uadc_pkg::UADC_ST_INIT;
		end else if (CLK_EN) begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// registered outputs
	logic attach_d;
	logic detach_d;
	assign attach_d = (state_d == uadc_pkg::UADC_ST_ATTACHED);
	assign detach_d = (state_d == uadc_pkg::UADC_ST_DETACHED);

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			INT_PULLUP_EN     <= 1'b0; // RULE16
			LINE_DRIVE_ALLOW  <= 1'b0;
			INBAND_WAKE_ALLOW <= 1'b0;
			DETACHED          <= 1'b0;
			BUS_POWER_RAIL_OK <= 1'b0;
		end else if (CLK_EN) begin
			INT_PULLUP_EN     <= attach_d && !pull_ext_q; // RULE4 RULE5
			LINE_DRIVE_ALLOW  <= attach_d; // RULE9 RULE10 RULE2
			INBAND_WAKE_ALLOW <= attach_d; // RULE12
			DETACHED          <= detach_d;
			BUS_POWER_RAIL_OK <= power_ok;
		end
	end

	// policy flags: fixed peripheral only and full speed only; bus power declaration follows config
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HS_CHIRP_INHIBIT  <= 1'b1;
			PERIPHERAL_ONLY   <= 1'b1;
			DECLARE_BUS_POWER <= 1'b0;
		end else if (CLK_EN) begin
			HS_CHIRP_INHIBIT  <= 1'b1; // RULE13
			PERIPHERAL_ONLY   <= 1'b1; // RULE1 RULE3
			DECLARE_BUS_POWER <= bus_pwr_q; // RULE14
		end
	end

	// io pin drivers: wake and external pull-up
	genvar gi;
	generate
		for (gi = 0; gi < `UADC_PIN_COUNT; gi++) begin : g_pin
			always_ff @(posedge CLOCK or posedge SYS_RST) begin
				if (SYS_RST) begin
					PROGRAMMABLE_IO_PIN_OUT[gi] <= 1'b0;
					PROGRAMMABLE_IO_PIN_OE[gi]  <= 1'b0;
				end else if (CLK_EN) begin
					if (cfg_done_q && wake_pin_q == `UADC_PIN_IDX_W'(gi)) begin
						PROGRAMMABLE_IO_PIN_OE[gi]  <= 1'b1;
						PROGRAMMABLE_IO_PIN_OUT[gi] <= detach_d && CORE_WAKE_REQ; // RULE11
					end else if (cfg_done_q && pull_ext_q
							&& pull_pin_q == `UADC_PIN_IDX_W'(gi)) begin
						// drive only when high; float otherwise so d+ is not pulled down
						PROGRAMMABLE_IO_PIN_OE[gi]  <= attach_d; // RULE5
						PROGRAMMABLE_IO_PIN_OUT[gi] <= attach_d;
					end else begin
						PROGRAMMABLE_IO_PIN_OE[gi]  <= 1'b0;
						PROGRAMMABLE_IO_PIN_OUT[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// checks
	sequence detach_seen_s;
		CLK_EN && detach_s;
	endsequence

	detach_floats_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE9
		detach_seen_s |=> (!INT_PULLUP_EN && !LINE_DRIVE_ALLOW))
		else $error("lines not floated while detached");
	wake_only_detached_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE11
		PROGRAMMABLE_IO_PIN_OUT[wake_pin_q] && PROGRAMMABLE_IO_PIN_OE[wake_pin_q]
		|-> DETACHED)
		else $error("wake high while attached");
	no_power_no_pull_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE6
		CLK_EN && !sense_s |=> !INT_PULLUP_EN)
		else $error("pull-up on without bus power");
	no_inband_wake_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE12
		DETACHED |-> !INBAND_WAKE_ALLOW)
		else $error("in-band wake allowed while detached");
	init_quiet_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE16
		!cfg_done_q |-> !INT_PULLUP_EN && !LINE_DRIVE_ALLOW && PROGRAMMABLE_IO_PIN_OE == '0)
		else $error("outputs active before config");
	ready_gates_pull_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE4
		CLK_EN && !CORE_READY |=> !INT_PULLUP_EN)
		else $error("pull-up without ready");
	ext_pull_src_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE5
		CLK_EN && pull_ext_q |=> !INT_PULLUP_EN)
		else $error("internal pull-up used in external mode");
	reconnect_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE10
		CLK_EN && DETACHED && !detach_s |=> !DETACHED)
		else $error("no reconnect after detach release");
	full_speed_a: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE13
		HS_CHIRP_INHIBIT && PERIPHERAL_ONLY)
		else $error("high speed or host role enabled");
endmodule : uadc_attach_ctrl

// file: uadc_host_model.sv
`timescale 1ns/1ns
`include "uadc_defines.svh"
module uadc_host_model (
	input  wire logic                        bus_on,
	input  wire logic                        detach_req,
	input  wire logic [`UADC_PIN_IDX_W-1:0]  sense_idx,
	input  wire logic [`UADC_PIN_IDX_W-1:0]  detach_idx,
	input  wire logic [`UADC_PIN_COUNT-1:0]  pin_out,
	input  wire logic [`UADC_PIN_COUNT-1:0]  pin_oe,
	output logic      [`UADC_PIN_COUNT-1:0]  pin_lvl
);
	// ==========================================
	// pin levels
	// weak pull-downs: an undriven pin reads low, never a stale value
	always_comb begin
		for (int i = 0; i < `UADC_PIN_COUNT; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : 1'b0;
			if (4'(i) == sense_idx) pin_lvl[i] = bus_on;
			if (4'(i) == detach_idx) pin_lvl[i] = detach_req;
		end
	end
endmodule : uadc_host_model

// file: usb_attach_detach_control_tb_top.sv
`timescale 1ns/1ns
`include "uadc_defines.svh"
`define CHK(o, e) begin compares++; if ((o) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t obs=%h exp=%h", $time, o, e); end end
module usb_attach_detach_control_tb_top;
	typedef struct packed {logic [10:0] v; logic [10:0] m;} uadc_note_t;
	logic        clock = 1'b0;
	logic        sys_rst, cfg_valid, cfg_ext, cfg_bp, clk_en;
	logic        bus_on, detach_req, core_ready, wake_req;
	logic [3:0]  sp, dp, wp, pp;
	logic [9:0]  pin_in, pin_out, pin_oe;
	logic        pu, drv, ibw, hsi, po, dbp, bpok, det, cfg_done;
	logic [10:0] obs;
	logic [31:0] r;
	int          error_cnt, compares, seed;
	uadc_note_t  q[$];
	uadc_note_t  n;
	uadc_note_t  last_e;
	uadc_attach_ctrl u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en),
		.CFG_VALID(cfg_valid), .CFG_PULL_EXTERNAL(cfg_ext), .CFG_BUS_POWERED(cfg_bp),
		.CFG_SENSE_PIN(sp), .CFG_DETACH_PIN(dp), .CFG_WAKE_PIN(wp), .CFG_PULLUP_PIN(pp),
		.CORE_READY(core_ready), .CORE_WAKE_REQ(wake_req), .PROGRAMMABLE_IO_PIN_IN(pin_in),
		.PROGRAMMABLE_IO_PIN_OUT(pin_out), .PROGRAMMABLE_IO_PIN_OE(pin_oe),
		.INT_PULLUP_EN(pu), .LINE_DRIVE_ALLOW(drv), .INBAND_WAKE_ALLOW(ibw),
		.HS_CHIRP_INHIBIT(hsi), .PERIPHERAL_ONLY(po), .DECLARE_BUS_POWER(dbp),
		.BUS_POWER_RAIL_OK(bpok), .DETACHED(det));
	uadc_host_model u_host (.bus_on(bus_on), .detach_req(detach_req), .sense_idx(sp),
		.detach_idx(dp), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_in));
	assign obs = {pu, drv, det, bpok, pin_out[wp], pin_oe[wp], pin_oe[pp], ibw, hsi, po, dbp};
	// ==========================================
	// expectations
	function automatic uadc_note_t expect_now();
		logic att, dt;
		uadc_note_t e;
		att = cfg_done & bus_on & ~detach_req & core_ready;
		// detach needs no bus power
		dt = cfg_done & detach_req;
		e.v = {att & ~cfg_ext, att, dt, bus_on, dt & wake_req, cfg_done, att & cfg_ext, att, 2'b11,
			cfg_done & cfg_bp};
		// before config the sensed pin may not be the one the model drives
		e.m = {3'h7, cfg_done, 7'h7F};
		return e;
	endfunction : expect_now
	// reattach from detached takes four edges: two sync, off, attached
	task automatic step(input logic b, input logic d, input logic rd, input logic w);
		bus_on = b;
		detach_req = d;
		core_ready = rd;
		wake_req = w;
		repeat (4) @(negedge clock);
		// a frozen block still shows the last settled result
		if (clk_en) begin
			last_e = expect_now();
		end
		q.push_back(last_e);
	endtask : step
	task automatic configure(input logic ext, input logic bp);
		cfg_valid = 1'b1;
		cfg_ext = ext;
		cfg_bp = bp;
		@(negedge clock);
		cfg_valid = 1'b0;
		cfg_done = 1'b1;
	endtask : configure
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// ==========================================
	// monitor
	always @(negedge clock) begin
		// just after the falling edge, so a note pushed there is seen in its own cycle
		#1;
		if (q.size() > 0) begin
			n = q.pop_front();
			`CHK(obs & n.m, n.v & n.m)
		end
	end
	initial begin
		forever #2 clock = ~clock;
	end
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
	// ==========================================
	// stimulus
	initial begin
		{sys_rst, cfg_valid, cfg_ext, cfg_bp} = 4'h8;
		{bus_on, detach_req, core_ready, wake_req} = 4'h0;
		clk_en = 1'b1;
		{sp, dp, wp, pp} = {4'h2, 4'h3, 4'h4, 4'h5};
		cfg_done = 1'b0;
		error_cnt = 0;
		compares = 0;
		seed = 32'h1E3C6A36;
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		step(1, 0, 1, 0);
		step(1, 1, 1, 1);
		configure(1'b0, 1'b0);
		step(1, 0, 1, 0);
		step(1, 1, 1, 1);
		step(1, 0, 1, 1);
		// enable low: a detach request must not move anything
		clk_en = 1'b0;
		step(1, 1, 1, 1);
		clk_en = 1'b1;
		step(1, 1, 1, 1);
		step(0, 1, 1, 1);
		step(0, 0, 1, 0);
		step(1, 0, 0, 0);
		// second reset mid-run must return to the quiet state
		@(negedge clock);
		sys_rst = 1'b1;
		cfg_done = 1'b0;
		r = $random(seed);
		sp = 4'(r[7:0] % 10);
		dp = 4'((r[7:0] + 1) % 10);
		wp = 4'((r[7:0] + 2) % 10);
		pp = 4'((r[7:0] + 3) % 10);
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		step(1, 0, 1, 0);
		configure(1'b1, 1'b1);
		for (int k = 0; k < 40; k++) begin
			r = $random(seed);
			step(r[0], r[1], r[2], r[3]);
		end
		repeat (3) @(negedge clock);
		print_verdict();
	end
endmodule : usb_attach_detach_control_tb_top
